// *** src/ibfws_pkg.sv ***
`default_nettype none
package ibfws_pkg;
	localparam int ADDR_W      = 24;
	localparam int TGT_W       = 16;
	localparam int WALK_LAST   = 3;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h00_0000;

	typedef enum logic [1:0] {
		IBFWS_WALK0 = 2'b00,
		IBFWS_WALK1 = 2'b01,
		IBFWS_WALK2 = 2'b11,
		IBFWS_WALK3 = 2'b10
	} ibfws_walk_e;

	typedef struct packed {
		logic [ADDR_W-1:0] lower;
		logic [ADDR_W-1:0] upper;
	} ibfws_src_lim_s;

	typedef struct packed {
		logic [TGT_W-1:0] u_low;
		logic [TGT_W-1:0] u_high;
		logic [TGT_W-1:0] v_low;
		logic [TGT_W-1:0] v_high;
		logic [TGT_W-1:0] w_low;
		logic [TGT_W-1:0] w_high;
	} ibfws_tgt_win_s;
endpackage : ibfws_pkg
`default_nettype wire

// *** src/ibfws_top.sv ***
`default_nettype none
module ibfws_top
	import ibfws_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  load,
	input  wire ibfws_src_lim_s        src_lim_in,
	input  wire ibfws_tgt_win_s        tgt_win_in,
	input  wire logic                  three_d_in,
	input  wire logic                  bilinear_in,
	input  wire logic                  start,
	input  wire logic [ADDR_W-1:0]     src_start,
	input  wire logic [ADDR_W-1:0]     src_step,
	input  wire logic [ADDR_W-1:0]     walk_step,
	input  wire logic [TGT_W-1:0]      tgt_u,
	input  wire logic [TGT_W-1:0]      tgt_v,
	input  wire logic [TGT_W-1:0]      tgt_w,
	output logic [ADDR_W-1:0]          source_address_bus,
	output logic                       source_in_bounds_flag_n,
	output logic                       target_in_window_flag,
	output logic                       src_read,
	output logic                       mac_clear,
	output logic                       dst_write,
	output logic [1:0]                 walk_index
);
	////////////////////////////////////////////////////////////////////
	// target dimension indices
	localparam int TGT_DIMS = 3;
	localparam int DIM_U    = 0;
	localparam int DIM_V    = 1;
	localparam int DIM_W    = 2;

	////////////////////////////////////////////////////////////////////
	// shared decoding
	function automatic logic src_inside(
		input logic [ADDR_W-1:0] value,
		input logic [ADDR_W-1:0] low,
		input logic [ADDR_W-1:0] high
	);
		src_inside = (value >= low) && (value <= high);
	endfunction : src_inside

	// both limits inclusive, as on the source side
	function automatic logic tgt_inside(
		input logic [TGT_W-1:0] value,
		input logic [TGT_W-1:0] low,
		input logic [TGT_W-1:0] high
	);
		tgt_inside = (value >= low) && (value <= high);
	endfunction : tgt_inside

	////////////////////////////////////////////////////////////////////
	// storage
	ibfws_src_lim_s           lim_reg;
	ibfws_tgt_win_s           win_reg;
	logic                     three_d_reg;
	logic                     bilinear_reg;
	logic                     run_reg;
	logic [ADDR_W-1:0]        base_reg;
	logic [ADDR_W-1:0]        addr_reg;
	ibfws_walk_e              walk_reg;
	logic                     dst_write_reg;

	////////////////////////////////////////////////////////////////////
	// next values and decode
	logic                     run_next;
	logic [ADDR_W-1:0]        base_next;
	logic [ADDR_W-1:0]        addr_next;
	ibfws_walk_e              walk_next;
	ibfws_walk_e              walk_seq;
	logic                     dst_write_next;
	logic                     walk_end;
	logic                     group_end;
	logic [ADDR_W-1:0]        base_adv;
	logic [ADDR_W-1:0]        walk_adv;
	logic [ADDR_W-1:0]        step_addr;
	logic                     src_ok;
	wire logic [TGT_W-1:0]    tgt_coord [TGT_DIMS];
	wire logic [TGT_W-1:0]    tgt_low   [TGT_DIMS];
	wire logic [TGT_W-1:0]    tgt_high  [TGT_DIMS];
	logic [TGT_DIMS-1:0]      dim_used;
	wire logic [TGT_DIMS-1:0] dim_ok;

	////////////////////////////////////////////////////////////////////
	// parameter copies private to this instance
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lim_reg <= '0;
		end else if (load) begin
			lim_reg <= src_lim_in;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			win_reg <= '0;
		end else if (load) begin
			win_reg <= tgt_win_in;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			three_d_reg <= 1'b0;
		end else if (load) begin
			three_d_reg <= three_d_in;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bilinear_reg <= 1'b0;
		end else if (load) begin
			bilinear_reg <= bilinear_in;
		end
	end

	////////////////////////////////////////////////////////////////////
	// address stepping; start wins over a running walk
	assign walk_end       = ~bilinear_reg | (walk_reg == IBFWS_WALK3);
	assign group_end      = run_reg & walk_end;
	assign base_adv       = base_reg + src_step;
	assign walk_adv       = addr_reg + walk_step;
	assign step_addr      = walk_end ? base_adv : walk_adv;
	assign run_next       = start | run_reg;
	assign base_next      = start ? src_start : (group_end ? base_adv : base_reg);
	assign addr_next      = start ? src_start : (run_reg ? step_addr : addr_reg);
	assign dst_write_next = ~start & group_end;

	////////////////////////////////////////////////////////////////////
	// walk sequencing
	always_comb begin
		walk_seq = IBFWS_WALK0;
		if (bilinear_reg) begin
			unique case (walk_reg)
				IBFWS_WALK0: walk_seq = IBFWS_WALK1;
				IBFWS_WALK1: walk_seq = IBFWS_WALK2;
				IBFWS_WALK2: walk_seq = IBFWS_WALK3;
				IBFWS_WALK3: walk_seq = IBFWS_WALK0;
			endcase
		end
	end

	always_comb begin
		walk_next = walk_reg;
		if (start) begin
			walk_next = IBFWS_WALK0;
		end else if (run_reg) begin
			walk_next = walk_seq;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sequencer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_reg <= 1'b0;
		end else begin
			run_reg <= run_next;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			base_reg <= ADDR_RESET;
		end else begin
			base_reg <= base_next;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr_reg <= ADDR_RESET;
		end else begin
			addr_reg <= addr_next;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			walk_reg <= IBFWS_WALK0;
		end else begin
			walk_reg <= walk_next;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dst_write_reg <= 1'b0;
		end else begin
			dst_write_reg <= dst_write_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// target window, w only counts in 3D
	assign tgt_coord[DIM_U] = tgt_u;
	assign tgt_coord[DIM_V] = tgt_v;
	assign tgt_coord[DIM_W] = tgt_w;
	assign tgt_low[DIM_U]   = win_reg.u_low;
	assign tgt_low[DIM_V]   = win_reg.v_low;
	assign tgt_low[DIM_W]   = win_reg.w_low;
	assign tgt_high[DIM_U]  = win_reg.u_high;
	assign tgt_high[DIM_V]  = win_reg.v_high;
	assign tgt_high[DIM_W]  = win_reg.w_high;
	assign dim_used         = {three_d_reg, 1'b1, 1'b1};

	for (genvar g = 0; g < TGT_DIMS; g++) begin : g_dim
		assign dim_ok[g] = tgt_inside(tgt_coord[g], tgt_low[g], tgt_high[g]) | ~dim_used[g];
	end

	////////////////////////////////////////////////////////////////////
	// flags and outputs
	assign src_ok                  = src_inside(addr_reg, lim_reg.lower, lim_reg.upper);
	assign source_address_bus      = addr_reg;
	assign source_in_bounds_flag_n = ~src_ok;
	assign target_in_window_flag   = &dim_ok;
	assign src_read                = run_reg;
	assign mac_clear               = run_reg & (walk_reg == IBFWS_WALK0);
	assign dst_write               = dst_write_reg;
	assign walk_index              = walk_reg;
endmodule : ibfws_top
`default_nettype wire

// *** verification/ibfws_props.sv ***
`default_nettype none
module ibfws_props
	import ibfws_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              start,
	input wire logic              src_read,
	input wire logic              mac_clear,
	input wire logic              dst_write,
	input wire logic [1:0]        walk_index,
	input wire logic [ADDR_W-1:0] src_start,
	input wire logic [ADDR_W-1:0] src_step,
	input wire logic [ADDR_W-1:0] walk_step,
	input wire logic [ADDR_W-1:0] source_address_bus
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic [ADDR_W-1:0] a = source_address_bus;
	wire logic w1 = src_read && walk_index == IBFWS_WALK1;
	wire logic w3 = src_read && walk_index == IBFWS_WALK3;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	start_addr_a: assert property (start |=> a == $past(src_start)) else $error("start");
	run_begin_a: assert property (start |=> src_read) else $error("no read");
	walk_step_a: assert property (w1 ##1 !start |-> a == $past(a) + $past(walk_step))
		else $error("walk");
	group_step_a: assert property (w3 ##1 !start |->
		a == ADDR_W'($past(a) + $past(src_step) - 3 * $past(walk_step))) else $error("group");
	walk_write_a: assert property (w3 ##1 !start |-> dst_write) else $error("no write");
	walk_order_a: assert property (w1 ##1 !start |-> walk_index == IBFWS_WALK2)
		else $error("order");
	mid_quiet_a: assert property (w1 |-> !dst_write) else $error("early write");
	walk_clear_a: assert property (start |=> mac_clear && !dst_write)
		else $error("clear");
	write_clear_a: assert property (dst_write |-> mac_clear) else $error("no clear");
endmodule : ibfws_props
bind ibfws_top ibfws_props ibfws_props_i (.*);
`default_nettype wire

// *** verification/ibfws_mem_model.sv ***
`default_nettype none
module ibfws_mem_model (
	input  wire logic clk,
	input  wire logic dst_write,
	output var  int   n_wr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial n_wr = 0;
	always @(posedge clk) if (dst_write) n_wr <= n_wr + 1;
endmodule : ibfws_mem_model
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
module tb_top import ibfws_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, load = 0, start = 0, three_d_in = 1, bilinear_in = 0;
	logic source_in_bounds_flag_n, target_in_window_flag, src_read, mac_clear, dst_write;
	logic [1:0] walk_index;
	logic [ADDR_W-1:0] src_start = '0, src_step = '0, walk_step = '0, source_address_bus;
	logic [TGT_W-1:0] tgt_u = '0, tgt_v = '0, tgt_w = '0;
	ibfws_src_lim_s src_lim_in = '{24'h00_0010, 24'h00_0020};
	// one window 5..9 on each of u, v and w
	ibfws_tgt_win_s tgt_win_in = '{16'h0005, 16'h0009, 16'h0005, 16'h0009, 16'h0005, 16'h0009};
	int n_fail = 0, n_tests = 0, n_wr, n0;
	ibfws_top ibfws_top_i (.*);
	ibfws_mem_model ibfws_mem_model_i (.*);
	task automatic chk(input logic [ADDR_W-1:0] s, e);
		n_tests++;
		if (s !== e) $display("ERROR %0t %h %h", $time, s, e);
		if (s !== e) n_fail++;
	endtask : chk
	task automatic give_verdict;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task automatic tw(input logic [TGT_W-1:0] u, v, w, input logic e);
		{tgt_u, tgt_v, tgt_w} = {u, v, w};
		#1 chk(target_in_window_flag, e);
		@(negedge clk);
	endtask : tw
	// load the mode, then start one cycle later
	task automatic go(input logic d, b, input logic [ADDR_W-1:0] s, p, q);
		{three_d_in, bilinear_in, load} = {d, b, 1'b1};
		@(negedge clk) {load, start, src_start, src_step, walk_step} = {2'b01, s, p, q};
		@(negedge clk) start = 0;
	endtask : go
	initial forever #50 clk = ~clk;
	initial begin
		#50_000;
		n_fail++;
		give_verdict;
	end
	initial begin
		repeat (2) @(negedge clk);
		rst = 0;
		chk(source_address_bus, ADDR_RESET);
		chk(source_in_bounds_flag_n, 1'b0);
		go(1, 0, 24'h00_000E, 24'h00_0001, '0);
		for (int i = 0; i < 20; i++) begin
			chk(source_address_bus, 24'h00_000E + i);
			chk(source_in_bounds_flag_n, i < 2 || i > 18);
			chk({src_read, dst_write}, {1'b1, i > 0});
			@(negedge clk);
		end
		tw(5, 5, 5, 1);
		tw(9, 9, 9, 1);
		tw(4, 9, 5, 0);
		tw(5, 10, 5, 0);
		tw(5, 5, 4, 0);
		rst = 1;
		@(negedge clk) rst = 0;
		chk({src_read, dst_write, walk_index}, 4'h0);
		go(0, 1, 24'h00_0100, 24'h00_0010, 24'h00_0002);
		n0 = n_wr;
		for (int i = 0; i < 12; i++) begin
			chk(source_address_bus, 24'h00_0100 + i / 4 * 16 + i % 4 * 2);
			chk(walk_index, 8'hB4 >> i % 4 * 2 & 3);
			chk({mac_clear, dst_write}, {i % 4 == 0, i > 3 && i % 4 == 0});
			@(negedge clk);
		end
		chk(n_wr, n0 + 2);
		tw(5, 5, 4, 1);
		give_verdict;
	end
endmodule : tb_top
`default_nettype wire
